// [shared/bdma_map.svh]
// Purpose: Offsets, field positions, reset values and bounds for the bank addressing block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef BDMA_MAP_SVH
`define BDMA_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define BDMA_OFF_BANK_SELECT  12'h000
`define BDMA_OFF_STATUS       12'h004
`define BDMA_OFF_BANK_IMPL    12'h008

// ****************************************************************
// Fields, reset values and Access Bank bounds
// ****************************************************************
`define BDMA_BSEL_MSB         3
`define BDMA_BSEL_RST         8'h00
`define BDMA_IMPL_RST         16'hFFFF
`define BDMA_ACC_LOW_LAST     8'h5F
`define BDMA_ACC_HIGH_BANK    4'hF
`define BDMA_ACC_LOW_BANK     4'h0

`endif

// [shared/bdma_pkg.sv]
// Purpose: Types for the bank addressing block
// Assumes: Constants come from bdma_map.svh
// Notes:   Operation codes from the instruction decoder
package bdma_pkg;

  typedef enum logic [1:0] {
    BDMA_OP_NONE  = 2'b00,
    BDMA_OP_FILE  = 2'b01,
    BDMA_OP_MOVE  = 2'b10,
    BDMA_OP_LOADB = 2'b11
  } bdma_op_t;

  typedef struct packed {
    bdma_op_t    op;
    logic        access_sel;
    logic [7:0]  file_addr;
    logic        wr;
    logic [7:0]  wdata;
    logic [11:0] src_addr;
    logic [11:0] dst_addr;
    logic [7:0]  literal;
    logic        upd_flags;
    logic [4:0]  flags;
  } bdma_req_t;

  typedef struct packed {
    logic        en;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } bdma_ram_t;

  typedef enum logic [1:0] {
    BDMA_ST_IDLE  = 2'b00,
    BDMA_ST_READ  = 2'b01,
    BDMA_ST_WRITE = 2'b10
  } bdma_state_t;

endpackage

// [src/bdma_core.sv]
// Notes on behaviour
// [RULE1] Access Bank: top 160 of bank 15, low 96 of bank 0
// [RULE2] Access bit picks selected bank or Access Bank
// [RULE3] Access mode: low part runs straight into high
// [RULE4] Access Bank High reaches special function registers unbanked
// [RULE5] Sixteen banks chosen by bank selector
// [RULE6] Bank selector low nibble gives address top bits
// [RULE7] Selector upper nibble reads zero, ignores writes
// [RULE8] Unimplemented bank: reads zero, writes dropped
// [RULE9] Status flags still update on unimplemented bank
// [RULE10] Each bank spans offsets up to FFh
// [RULE11] Register move uses full 12-bit instruction addresses
// [RULE12] Dedicated load instruction sets bank selector
// [RULE13] Access offsets 00-5F low, 60-FF to F60-FFF
// [RULE14] Banked address is selector nibble over offset
//
// Purpose: Direct data memory addressing with bank select and Access Bank
// Assumes: Decoder requests at least two cycles apart after a read and three after a move, RAM read data valid while ram.en stands
// Notes:   Registers also reachable over APB
`timescale 1ns/100ps
`include "bdma_map.svh"

module bdma_core
  import bdma_pkg::*;
#(
  parameter int BANKS = 16
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire bdma_req_t   req,
  input  wire logic        req_valid,
  input  wire logic [7:0]  ram_rdata,
  output bdma_ram_t        ram,
  output logic [7:0]       rdata,
  output logic             rdata_valid,
  output logic [4:0]       status_flags,
  output logic [7:0]       bank_select,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  if (BANKS != 16) begin : g_banks_chk
    $error("bdma_core serves sixteen banks only");
  end

  // ****************************************************************
  // Address forming
  // ****************************************************************
  function automatic logic [11:0] direct_addr(input logic a, input logic [7:0] off,
                                              input logic [3:0] bnk);
    if (a) begin
      direct_addr = {bnk, off};                                 // [RULE14] [RULE6] [RULE10]
    end else if (off <= `BDMA_ACC_LOW_LAST) begin
      direct_addr = {`BDMA_ACC_LOW_BANK, off};                  // [RULE1] [RULE13]
    end else begin
      direct_addr = {`BDMA_ACC_HIGH_BANK, off};                 // [RULE3] [RULE4] [RULE13]
    end
  endfunction

  function automatic logic bank_ok(input logic [15:0] impl, input logic [11:0] addr);
    bank_ok = impl[addr[11:8]];                                 // [RULE5]
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  bdma_state_t state_reg, state_next;
  logic [3:0]  bsel_reg, bsel_next;
  logic [15:0] impl_reg, impl_next;
  logic [4:0]  flags_reg, flags_next;
  bdma_ram_t   ram_reg, ram_next;
  logic [11:0] mv_dst_reg, mv_dst_next;
  logic        zero_rd_reg, zero_rd_next;
  logic        mv_reg, mv_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        rvalid_reg, rvalid_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic [11:0] eff;
  logic        apb_acc;
  logic        apb_wr;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next   = state_reg;
    bsel_next    = bsel_reg;
    impl_next    = impl_reg;
    flags_next   = flags_reg;
    ram_next     = '0;
    mv_dst_next  = mv_dst_reg;
    zero_rd_next = 1'b0;
    mv_next      = 1'b0;
    rdata_next   = rdata_reg;
    rvalid_next  = 1'b0;
    prdata_next  = prdata_reg;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    eff          = direct_addr(req.access_sel, req.file_addr, bsel_reg);
    apb_acc      = psel && penable && !pready_reg;
    apb_wr       = psel && penable && pwrite && pready_reg;

    unique case (state_reg)
      BDMA_ST_IDLE: begin
        if (req_valid) begin
          if (req.upd_flags) begin
            flags_next = req.flags;                             // [RULE9]
          end
          unique case (req.op)
            BDMA_OP_NONE: begin
            end
            BDMA_OP_FILE: begin
              if (bank_ok(impl_reg, eff)) begin
                ram_next.en    = 1'b1;                          // [RULE2]
                ram_next.wr    = req.wr;
                ram_next.addr  = eff;
                ram_next.wdata = req.wdata;
                state_next     = req.wr ? BDMA_ST_IDLE : BDMA_ST_READ;
              end else if (!req.wr) begin
                zero_rd_next   = 1'b1;                          // [RULE8]
                state_next     = BDMA_ST_READ;
              end
            end
            BDMA_OP_MOVE: begin
              mv_next     = 1'b1;
              mv_dst_next = req.dst_addr;                       // [RULE11]
              if (bank_ok(impl_reg, req.src_addr)) begin
                ram_next.en   = 1'b1;
                ram_next.addr = req.src_addr;                   // [RULE11]
              end else begin
                zero_rd_next  = 1'b1;                           // [RULE8]
              end
              state_next = BDMA_ST_READ;
            end
            BDMA_OP_LOADB: begin
              bsel_next = req.literal[`BDMA_BSEL_MSB:0];        // [RULE12] [RULE7]
            end
          endcase
        end
      end
      BDMA_ST_READ: begin
        rdata_next  = zero_rd_reg ? 8'h00 : ram_rdata;          // [RULE8]
        rvalid_next = 1'b1;
        state_next  = mv_reg ? BDMA_ST_WRITE : BDMA_ST_IDLE;
        if (mv_reg && bank_ok(impl_reg, mv_dst_reg)) begin
          ram_next.en    = 1'b1;
          ram_next.wr    = 1'b1;
          ram_next.addr  = mv_dst_reg;                          // [RULE11]
          ram_next.wdata = zero_rd_reg ? 8'h00 : ram_rdata;
        end
      end
      BDMA_ST_WRITE: begin
        state_next = BDMA_ST_IDLE;
      end
      default: begin
        state_next = BDMA_ST_IDLE;
      end
    endcase

    // APB slave, one wait state; writes land at the edge that sees pready
    if (apb_acc) begin
      pready_next = 1'b1;
      prdata_next = 32'h0000_0000;
      unique case (paddr)
        `BDMA_OFF_BANK_SELECT: begin
          prdata_next = {28'h000_0000, bsel_reg};               // [RULE7]
        end
        `BDMA_OFF_STATUS: begin
          prdata_next = {27'h000_0000, flags_reg};
        end
        `BDMA_OFF_BANK_IMPL: begin
          prdata_next = {16'h0000, impl_reg};
        end
        default: begin
          pslverr_next = 1'b1;
        end
      endcase
    end
    if (apb_wr && paddr == `BDMA_OFF_BANK_SELECT) begin
      bsel_next = pwdata[`BDMA_BSEL_MSB:0];                     // [RULE7]
    end
    if (apb_wr && paddr == `BDMA_OFF_BANK_IMPL) begin
      impl_next = pwdata[15:0];
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg   <= BDMA_ST_IDLE;
      bsel_reg    <= 4'(`BDMA_BSEL_RST);
      impl_reg    <= `BDMA_IMPL_RST;
      flags_reg   <= 5'h00;
      ram_reg     <= '0;
      mv_dst_reg  <= 12'h000;
      zero_rd_reg <= 1'b0;
      mv_reg      <= 1'b0;
      rdata_reg   <= 8'h00;
      rvalid_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      bsel_reg    <= bsel_next;
      impl_reg    <= impl_next;
      flags_reg   <= flags_next;
      ram_reg     <= ram_next;
      mv_dst_reg  <= mv_dst_next;
      zero_rd_reg <= zero_rd_next;
      mv_reg      <= mv_next;
      rdata_reg   <= rdata_next;
      rvalid_reg  <= rvalid_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign ram          = ram_reg;
  assign rdata        = rdata_reg;
  assign rdata_valid  = rvalid_reg;
  assign status_flags = flags_reg;
  assign bank_select  = {4'h0, bsel_reg};
  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;

endmodule

// [tb/bdma_core_sva.sv]
// Purpose: Port checker for bdma_core
// Assumes: Decoder requests spaced as the core needs
// Notes:   Bound after the module
`timescale 1ns/100ps
module bdma_core_sva
  import bdma_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire bdma_req_t  req,
  input wire logic       req_valid,
  input wire bdma_ram_t  ram,
  input wire logic       rdata_valid,
  input wire logic [4:0] status_flags,
  input wire logic [7:0] bank_select,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire       f   = req_valid && req.op == BDMA_OP_FILE;
  wire [7:0] fa  = req.file_addr;
  wire [3:0] bs  = bank_select[3:0];
  wire [3:0] lit = req.literal[3:0];
  sequence s_at(logic [11:0] a, logic w);
    ram.en && ram.wr == w && ram.addr == a;
  endsequence
  sequence s_mv;
    s_at($past(req.src_addr), 1'b0) ##1
      (rdata_valid && ram.en && ram.wr && ram.addr == $past(req.dst_addr, 2));
  endsequence
  nib_zero_a: assert property (bank_select[7:4] == 4'h0)
    else $error("bank_select upper nibble set");
  acc_map_a: assert property (f && !req.access_sel |=>
    s_at({($past(fa) > 8'h5F) ? 4'hF : 4'h0, $past(fa)}, $past(req.wr)))
    else $error("access bank address wrong");
  bnk_map_a: assert property (f && req.access_sel |=>
    !ram.en || ram.addr == {$past(bs), $past(fa)})
    else $error("banked address wrong");
  rd_lat_a: assert property (f && !req.wr |-> ##2 rdata_valid)
    else $error("read gave no result");
  mv_full_a: assert property (req_valid && req.op == BDMA_OP_MOVE |-> ##1 s_mv)
    else $error("move addresses wrong");
  ldb_a: assert property (req_valid && req.op == BDMA_OP_LOADB |=>
    bank_select == {4'h0, $past(lit)})
    else $error("bank load wrong");
  flg_upd_a: assert property (req_valid && req.upd_flags |=>
    status_flags == $past(req.flags))
    else $error("flags not updated");
  apb_rdy_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready timing wrong");
endmodule
bind bdma_core bdma_core_sva chk_u (.ref_clk, .sys_rst, .req, .req_valid, .ram,
  .rdata_valid, .status_flags, .bank_select, .psel, .penable, .pready);

// [tb/bdma_ram_model.sv]
// Purpose: Data RAM behind bdma_core
// Assumes: Read data stands in the cycle en stands
// Notes:   Idle output toggles
`timescale 1ns/100ps
module bdma_ram_model
  import bdma_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire bdma_ram_t ram,
  output logic [7:0]     ram_rdata
);
  // ****
  // Sixteen banks of 256 bytes
  // ****
  logic [7:0] mem [4096];
  logic [7:0] idle_q;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    idle_q = 8'h00;
  end
  always @(posedge ref_clk) begin
    if (ram.en && ram.wr) mem[ram.addr] <= ram.wdata;
    idle_q <= ~idle_q;
  end
  assign ram_rdata = (ram.en && !ram.wr) ? mem[ram.addr] : idle_q;
endmodule

// [tb/tb_banked_data_memory_addressing.sv]
// Purpose: Bench for bdma_core
// Assumes: APB master and decoder tasks
// Notes:   Fixed waits follow core latency
`timescale 1ns/100ps
`include "bdma_map.svh"
module tb_banked_data_memory_addressing
  import bdma_pkg::*;
;
  // ****
  // Bench
  // ****
  localparam logic [11:0] a_bs = `BDMA_OFF_BANK_SELECT;
  localparam logic [11:0] a_st = `BDMA_OFF_STATUS;
  localparam logic [11:0] a_im = `BDMA_OFF_BANK_IMPL;
  logic        ref_clk = 0, sys_rst = 1, req_valid = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  bdma_req_t   req = '0;
  bdma_ram_t   ram;
  logic [7:0]  ram_rdata, rdata, bank_select;
  logic [4:0]  status_flags;
  logic        rdata_valid, pready, pslverr, e;
  int          fails = 0, n_checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  bdma_core dut_u (.ref_clk, .sys_rst, .req, .req_valid, .ram_rdata, .ram, .rdata,
    .rdata_valid, .status_flags, .bank_select, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);
  bdma_ram_model ram_u (.ref_clk, .ram, .ram_rdata);
  task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(string nm, logic [11:0] a, logic [31:0] x);
    apb(0, a, '0);
    chk(nm, x, q);
  endtask
  task automatic go(bdma_req_t x);
    @(posedge ref_clk);
    req <= x;
    req_valid <= 1;
    @(posedge ref_clk);
    req_valid <= 0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic fr(logic a, logic [7:0] o, logic w, logic [7:0] d);
    go('{BDMA_OP_FILE, a, o, w, d, 12'h000, 12'h000, 8'h00, 1'b1, o[4:0]});
  endtask
  task automatic frc(logic a, logic [7:0] o, logic [7:0] x);
    fr(a, o, 0, 8'h00);
    chk("rdata", x, rdata);
  endtask
  task automatic close_out;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #10000;
    fails++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 0;
    rd("bsel", a_bs, 32'h0000_0000);
    rd("impl", a_im, 32'h0000_FFFF);
    apb(0, 12'h00C, '0);
    chk("slverr", 1, e);
    wr_nib: apb(1, a_bs, 32'h0000_00A5);
    rd("bsel", a_bs, 32'h0000_0005);
    $display("test registers done");
    fr(1, 8'h33, 1, 8'h77);
    frc(1, 8'h33, 8'h77);
    frc(0, 8'h33, 8'h00);
    apb(1, a_bs, 32'h0000_000F);
    fr(1, 8'h60, 1, 8'h5A);
    fr(1, 8'hFF, 1, 8'hC3);
    apb(1, a_bs, 32'h0000_0000);
    fr(1, 8'h5F, 1, 8'h21);
    frc(0, 8'h5F, 8'h21);
    frc(0, 8'h60, 8'h5A);
    frc(0, 8'hFF, 8'hC3);
    $display("test mapping done");
    go('{BDMA_OP_LOADB, 1'b0, 8'h00, 1'b0, 8'h00, 12'h000, 12'h000, 8'h3C, 1'b0, 5'h00});
    chk("bank_select", 32'h0000_000C, bank_select);
    rd("loadb", a_bs, 32'h0000_000C);
    apb(1, a_im, 32'h0000_EFFF);
    fr(1, 8'h10, 1, 8'h99);
    frc(1, 8'h10, 8'h00);
    rd("flags", a_st, 32'h0000_0010);
    chk("status_flags", 32'h0000_0010, status_flags);
    apb(1, a_im, 32'h0000_FFFF);
    frc(1, 8'h10, 8'h00);
    $display("test absent bank done");
    go('{BDMA_OP_MOVE, 1'b1, 8'h00, 1'b0, 8'h00, 12'h533, 12'h234, 8'h00, 1'b0, 5'h00});
    chk("move", 8'h77, rdata);
    apb(1, a_bs, 32'h0000_0002);
    frc(1, 8'h34, 8'h77);
    $display("test move done");
    close_out();
  end
endmodule
